// file: ccmi_map.svh
// address map and field constants for the compare/move/idle/io execution block
`ifndef CCMI_MAP_SVH
`define CCMI_MAP_SVH

`define CCMI_WORD_W 16
`define CCMI_RAM_AW 9
`define CCMI_RAM_DEPTH 512
// configurable block, data memory only while the config bit is low
`define CCMI_BLK0_LO 16'h0200
`define CCMI_BLK0_HI 16'h02ff
// fixed data block, directly above the configurable one
`define CCMI_BLK1_LO 16'h0300
`define CCMI_BLK1_HI 16'h03ff
`define CCMI_CM_EQ 2'h0
`define CCMI_CM_LT 2'h1
`define CCMI_CM_GT 2'h2
`define CCMI_CM_NE 2'h3
`define CCMI_PC_RESET 16'h0000
`define CCMI_PC_STEP_ONE 16'h0001
`define CCMI_PC_STEP_TWO 16'h0002
`define CCMI_INT_W 8

`endif

// file: ccmi_pkg.sv
// types shared by the compare/move/idle/io execution block
`default_nettype none
`include "ccmi_map.svh"
package ccmi_pkg;
	typedef enum logic [2:0] {
		CCMI_OP_COMPARE,
		CCMI_OP_MOVE,
		CCMI_OP_IDLE,
		CCMI_OP_IO_IN,
		CCMI_OP_SWINT
	} ccmi_op_e;

	typedef enum logic [2:0] {
		CCMI_ST_READY,
		CCMI_ST_MOVE_WR,
		CCMI_ST_EXT_RD,
		CCMI_ST_IDLE
	} ccmi_state_e;

	typedef struct packed {
		ccmi_op_e op;
		logic [1:0] compare_mode_field;
		logic [`CCMI_WORD_W-1:0] data_addr;
		logic [`CCMI_WORD_W-1:0] port_address;
		logic [4:0] vector_index;
	} ccmi_instr_s;

	typedef struct packed {
		logic [`CCMI_WORD_W-1:0] addr;
		logic io_space_select_n;
		logic external_strobe_n;
		logic read_strobe_n;
	} ccmi_extbus_s;
endpackage
`default_nettype wire

// file: ccmi_data_ram.sv
// on-chip data ram: one write port, two registered read ports
`default_nettype none
`include "ccmi_map.svh"
module ccmi_data_ram
	import ccmi_pkg::*;
(
	input wire logic clock_in,
	input wire logic wr_en_in,
	input wire logic [`CCMI_RAM_AW-1:0] wr_addr_in,
	input wire logic [`CCMI_WORD_W-1:0] wr_data_in,
	input wire logic [`CCMI_RAM_AW-1:0] rd_a_addr_in,
	output logic [`CCMI_WORD_W-1:0] rd_a_data_out,
	input wire logic [`CCMI_RAM_AW-1:0] rd_b_addr_in,
	output logic [`CCMI_WORD_W-1:0] rd_b_data_out
);
	logic [`CCMI_WORD_W-1:0] mem_r [0:`CCMI_RAM_DEPTH-1];

	// no reset on the array: contents are undefined until written
	always_ff @(posedge clock_in) begin
		if (wr_en_in) begin
			mem_r[wr_addr_in] <= wr_data_in;
		end
		rd_a_data_out <= mem_r[rd_a_addr_in];
		rd_b_data_out <= mem_r[rd_b_addr_in];
	end
endmodule
`default_nettype wire

// file: ccmi_exec.sv
// execution unit for aux compare, data move, idle, io input and software interrupt
`default_nettype none
`include "ccmi_map.svh"
module ccmi_exec
	import ccmi_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic instr_valid_in,
	input wire ccmi_instr_s instr_in,
	input wire logic [`CCMI_WORD_W-1:0] cur_aux_in,
	input wire logic [`CCMI_WORD_W-1:0] index_aux_register_in,
	input wire logic sign_ext_mode_in,
	input wire logic ram_config_bit_in,
	input wire logic global_int_mask_set_in,
	input wire logic global_int_mask_clr_in,
	input wire logic [`CCMI_INT_W-1:0] int_request_in,
	input wire logic [`CCMI_INT_W-1:0] int_enable_in,
	input wire logic nmi_n_in,
	input wire logic ready_in,
	input wire logic [`CCMI_WORD_W-1:0] ext_data_in,
	input wire logic load_en_in,
	input wire logic [`CCMI_RAM_AW-1:0] load_addr_in,
	input wire logic [`CCMI_WORD_W-1:0] load_data_in,
	input wire logic [`CCMI_RAM_AW-1:0] peek_addr_in,
	output logic [`CCMI_WORD_W-1:0] peek_data_out,
	output logic busy_out,
	output logic done_out,
	output logic [`CCMI_WORD_W-1:0] pc_out,
	output logic test_control_flag_out,
	output logic sign_ext_mode_out,
	output logic global_int_mask_out,
	output logic idle_out,
	output logic wake_branch_out,
	output logic stack_push_out,
	output logic [`CCMI_WORD_W-1:0] stack_data_out,
	output ccmi_extbus_s ext_bus_out
);
	// ==========================================================
	// pin synchronisers
	logic nmi_m_r, nmi_s_r, rdy_m_r, rdy_s_r;
	logic [`CCMI_WORD_W-1:0] dat_m_r, dat_s_r;

	always_ff @(posedge clock_in) begin
		nmi_m_r <= ~nmi_n_in;
		nmi_s_r <= nmi_m_r;
		rdy_m_r <= ready_in;
		rdy_s_r <= rdy_m_r;
		dat_m_r <= ext_data_in;
		dat_s_r <= dat_m_r;
	end

	// ==========================================================
	// helpers
	function automatic logic on_chip(input logic [`CCMI_WORD_W-1:0] a, input logic ram_config_bit);
		on_chip = (a >= `CCMI_BLK1_LO && a <= `CCMI_BLK1_HI) ||
			(!ram_config_bit && a >= `CCMI_BLK0_LO && a <= `CCMI_BLK0_HI);
	endfunction

	function automatic logic cmp_hold(input logic [1:0] m, input logic [`CCMI_WORD_W-1:0] c,
		input logic [`CCMI_WORD_W-1:0] x);
		unique case (m)
			`CCMI_CM_EQ: cmp_hold = (c == x);
			`CCMI_CM_LT: cmp_hold = (c < x);
			`CCMI_CM_GT: cmp_hold = (c > x);
			`CCMI_CM_NE: cmp_hold = (c != x);
		endcase
	endfunction

	// ==========================================================
	// state
	ccmi_state_e state_r, state_nxt;
	ccmi_instr_s held_r, held_nxt;
	logic [`CCMI_WORD_W-1:0] pc_r, pc_nxt, stack_r, stack_nxt;
	logic tc_r, tc_nxt, global_int_mask_r, global_int_mask_nxt, done_r, done_nxt;
	logic wake_r, wake_nxt, push_r, push_nxt;
	logic busy_r, busy_nxt, idle_r, idle_nxt;
	ccmi_extbus_s bus_r, bus_nxt;
	logic ram_we;
	logic [`CCMI_RAM_AW-1:0] ram_waddr, ram_raddr;
	logic [`CCMI_WORD_W-1:0] ram_wdata, ram_rdata;
	logic [`CCMI_WORD_W-1:0] move_dst;
	logic wake_any;
	logic sxm_r;

	// peripherals are not gated by idle, so their requests keep arriving
	assign wake_any = (|(int_request_in & int_enable_in)) | nmi_s_r;
	assign move_dst = held_r.data_addr + `CCMI_PC_STEP_ONE;

	always_comb begin
		state_nxt = state_r;
		held_nxt = held_r;
		pc_nxt = pc_r;
		tc_nxt = tc_r;
		global_int_mask_nxt = global_int_mask_r;
		stack_nxt = stack_r;
		bus_nxt = bus_r;
		done_nxt = 1'b0;
		wake_nxt = 1'b0;
		push_nxt = 1'b0;
		ram_we = 1'b0;
		ram_waddr = move_dst[`CCMI_RAM_AW-1:0];
		ram_wdata = ram_rdata;
		ram_raddr = instr_in.data_addr[`CCMI_RAM_AW-1:0];
		if (global_int_mask_set_in) begin
			global_int_mask_nxt = 1'b1;
		end else if (global_int_mask_clr_in) begin
			global_int_mask_nxt = 1'b0;
		end
		unique case (state_r)
			CCMI_ST_READY: begin
				if (instr_valid_in) begin
					held_nxt = instr_in;
					unique case (instr_in.op)
						CCMI_OP_COMPARE: begin
							tc_nxt = cmp_hold(instr_in.compare_mode_field, cur_aux_in,
								index_aux_register_in);
							pc_nxt = pc_r + `CCMI_PC_STEP_ONE;
							done_nxt = 1'b1;
						end
						CCMI_OP_MOVE: begin
							pc_nxt = pc_r + `CCMI_PC_STEP_ONE;
							if (on_chip(instr_in.data_addr, ram_config_bit_in)) begin
								state_nxt = CCMI_ST_MOVE_WR;
							end else begin
								bus_nxt = '{addr: instr_in.data_addr, io_space_select_n: 1'b1,
									external_strobe_n: 1'b0, read_strobe_n: 1'b0};
								state_nxt = CCMI_ST_EXT_RD;
							end
						end
						CCMI_OP_IDLE: begin
							pc_nxt = pc_r + `CCMI_PC_STEP_ONE;
							state_nxt = CCMI_ST_IDLE;
						end
						CCMI_OP_IO_IN: begin
							pc_nxt = pc_r + `CCMI_PC_STEP_TWO;
							bus_nxt = '{addr: instr_in.port_address, io_space_select_n: 1'b0,
								external_strobe_n: 1'b0, read_strobe_n: 1'b0};
							state_nxt = CCMI_ST_EXT_RD;
						end
						CCMI_OP_SWINT: begin
							stack_nxt = pc_r + `CCMI_PC_STEP_ONE;
							push_nxt = 1'b1;
							pc_nxt = {10'h000, instr_in.vector_index, 1'b0};
							global_int_mask_nxt = 1'b1;
							done_nxt = 1'b1;
						end
						default: begin
							done_nxt = 1'b1;
						end
					endcase
				end
			end
			CCMI_ST_MOVE_WR: begin
				// source word came out of the ram this cycle
				ram_we = on_chip(move_dst, ram_config_bit_in);
				done_nxt = 1'b1;
				state_nxt = CCMI_ST_READY;
			end
			CCMI_ST_EXT_RD: begin
				if (rdy_s_r) begin
					bus_nxt.io_space_select_n = 1'b1;
					bus_nxt.external_strobe_n = 1'b1;
					bus_nxt.read_strobe_n = 1'b1;
					if (held_r.op == CCMI_OP_IO_IN) begin
						ram_waddr = held_r.data_addr[`CCMI_RAM_AW-1:0];
						ram_wdata = dat_s_r;
						ram_we = on_chip(held_r.data_addr, ram_config_bit_in);
					end
					done_nxt = 1'b1;
					state_nxt = CCMI_ST_READY;
				end
			end
			CCMI_ST_IDLE: begin
				// mask only decides what happens after the wake, not whether it happens
				if (wake_any) begin
					wake_nxt = ~global_int_mask_r;
					done_nxt = 1'b1;
					state_nxt = CCMI_ST_READY;
				end
			end
			default: begin
				state_nxt = CCMI_ST_READY;
			end
		endcase
		// status outputs registered from the next state so they leave a flop with no added lag
		busy_nxt = (state_nxt != CCMI_ST_READY);
		idle_nxt = (state_nxt == CCMI_ST_IDLE);
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state_r <= CCMI_ST_READY;
			held_r <= '0;
			pc_r <= `CCMI_PC_RESET;
			tc_r <= 1'b0;
			global_int_mask_r <= 1'b1;
			stack_r <= '0;
			bus_r <= '{addr: 16'h0000, io_space_select_n: 1'b1, external_strobe_n: 1'b1, read_strobe_n: 1'b1};
			done_r <= 1'b0;
			wake_r <= 1'b0;
			push_r <= 1'b0;
			busy_r <= 1'b0;
			idle_r <= 1'b0;
			sxm_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			held_r <= held_nxt;
			pc_r <= pc_nxt;
			tc_r <= tc_nxt;
			global_int_mask_r <= global_int_mask_nxt;
			stack_r <= stack_nxt;
			bus_r <= bus_nxt;
			done_r <= done_nxt;
			wake_r <= wake_nxt;
			push_r <= push_nxt;
			busy_r <= busy_nxt;
			idle_r <= idle_nxt;
			sxm_r <= sign_ext_mode_in;
		end
	end

	// ==========================================================
	// data ram; the load port yields to the block's own writes
	logic ram_we_any;
	logic [`CCMI_RAM_AW-1:0] ram_waddr_any;
	logic [`CCMI_WORD_W-1:0] ram_wdata_any;

	always_comb begin
		ram_we_any = ram_we | load_en_in;
		ram_waddr_any = ram_we ? ram_waddr : load_addr_in;
		ram_wdata_any = ram_we ? ram_wdata : load_data_in;
	end

	ccmi_data_ram u_ram (
		.clock_in(clock_in),
		.wr_en_in(ram_we_any),
		.wr_addr_in(ram_waddr_any),
		.wr_data_in(ram_wdata_any),
		.rd_a_addr_in(ram_raddr),
		.rd_a_data_out(ram_rdata),
		.rd_b_addr_in(peek_addr_in),
		.rd_b_data_out(peek_data_out)
	);

	assign busy_out = busy_r;
	assign done_out = done_r;
	assign pc_out = pc_r;
	assign test_control_flag_out = tc_r;
	assign sign_ext_mode_out = sxm_r;
	assign global_int_mask_out = global_int_mask_r;
	assign idle_out = idle_r;
	assign wake_branch_out = wake_r;
	assign stack_push_out = push_r;
	assign stack_data_out = stack_r;
	assign ext_bus_out = bus_r;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);

	logic accept;
	assign accept = instr_valid_in && state_r == CCMI_ST_READY;

	compare_result_a: assert property (accept && instr_in.op == CCMI_OP_COMPARE |=>
		tc_r == cmp_hold($past(instr_in.compare_mode_field), $past(cur_aux_in),
		$past(index_aux_register_in))) else $error("compare flag wrong");
	compare_lt_a: assert property (accept && instr_in.op == CCMI_OP_COMPARE &&
		instr_in.compare_mode_field == `CCMI_CM_LT && cur_aux_in < index_aux_register_in |=> tc_r)
		else $error("less-than compare not set");
	idle_pc_hold_a: assert property (state_r == CCMI_ST_IDLE && $past(state_r) == CCMI_ST_IDLE |->
		$stable(pc_r)) else $error("pc moved in idle");
	idle_enter_a: assert property (accept && instr_in.op == CCMI_OP_IDLE |=>
		pc_r == $past(pc_r) + 16'h0001 && idle_out) else $error("idle entry wrong");
	idle_wake_a: assert property (idle_out && wake_any |=> !idle_out && wake_branch_out == !$past(global_int_mask_r))
		else $error("idle wake wrong");
	swint_vector_a: assert property (accept && instr_in.op == CCMI_OP_SWINT |=>
		pc_r == {10'h000, $past(instr_in.vector_index), 1'b0} && stack_push_out &&
		stack_data_out == $past(pc_r) + 16'h0001 && global_int_mask_out)
		else $error("software interrupt wrong");
	io_select_a: assert property (accept && instr_in.op == CCMI_OP_IO_IN |=>
		!ext_bus_out.io_space_select_n && !ext_bus_out.external_strobe_n && !ext_bus_out.read_strobe_n)
		else $error("io select not low");
	ext_release_a: assert property (state_r == CCMI_ST_EXT_RD && rdy_s_r |=>
		ext_bus_out.external_strobe_n && ext_bus_out.read_strobe_n && done_out)
		else $error("strobe not released");
	move_ext_nowrite_a: assert property (state_r == CCMI_ST_EXT_RD && held_r.op == CCMI_OP_MOVE |->
		!ram_we) else $error("external move wrote ram");
	move_write_a: assert property (state_r == CCMI_ST_MOVE_WR && on_chip(move_dst, ram_config_bit_in) |->
		ram_we && ram_waddr == move_dst[8:0] && ram_wdata == ram_rdata)
		else $error("move write wrong");

	move_cov_c: cover property (state_r == CCMI_ST_MOVE_WR && ram_we);
	io_cov_c: cover property (state_r == CCMI_ST_EXT_RD && held_r.op == CCMI_OP_IO_IN && rdy_s_r);
	wake_masked_c: cover property (idle_out && wake_any && global_int_mask_r);
	swint_cov_c: cover property (accept && instr_in.op == CCMI_OP_SWINT);
endmodule
`default_nettype wire

// file: ccmi_io_model.sv
// external i/o peripheral model answering reads on the external bus
`default_nettype none
module ccmi_io_model (
	input wire logic clock_in,
	input wire logic read_strobe_n_in,
	input wire logic [15:0] word_in,
	input wire logic [3:0] delay_in,
	output logic ready_out,
	output logic [15:0] data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r;
	logic [15:0] last_r;
	initial begin
		ready_out = 1'b0;
		data_out = 16'h0000;
		cnt_r = 4'h0;
		last_r = 16'h0000;
	end
	// ready held until the strobe is released; released data flips so stale values never match
	always @(posedge clock_in) begin
		if (read_strobe_n_in === 1'b0) begin
			if (cnt_r == delay_in) begin
				ready_out <= 1'b1;
				data_out <= word_in;
				last_r <= word_in;
			end else begin
				cnt_r <= cnt_r + 4'h1;
			end
		end else begin
			ready_out <= 1'b0;
			cnt_r <= 4'h0;
			data_out <= ~last_r;
		end
	end
endmodule
`default_nettype wire

// file: tb_cpu_compare_move_idle_io.sv
// self-checking bench for the compare/move/idle/io execution block
`default_nettype none
`include "ccmi_map.svh"
module tb_cpu_compare_move_idle_io
	import ccmi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 1'b0, reset_in = 1'b1, instr_valid_in = 1'b0, sign_ext_mode_in = 1'b0;
	logic ram_config_bit_in = 1'b0, global_int_mask_set_in = 1'b0, global_int_mask_clr_in = 1'b0, nmi_n_in = 1'b1, load_en_in = 1'b0;
	ccmi_instr_s instr_in = '0;
	logic [15:0] cur_aux_in = '0, index_aux_register_in = '0, ext_data_in, load_data_in = '0, peek_data_out;
	logic [15:0] pc_out, stack_data_out, word = '0, exp_pc = '0, a, b, spc;
	logic [7:0] int_request_in = '0, int_enable_in = '0;
	logic [8:0] load_addr_in = '0, peek_addr_in = '0;
	logic [3:0] delay = 4'h0;
	logic ready_in, busy_out, done_out, test_control_flag_out, sign_ext_mode_out, global_int_mask_out;
	logic idle_out, wake_branch_out, stack_push_out, exp_tc = 1'b0, sel_seen;
	ccmi_extbus_s ext_bus_out;
	logic [16:0] expq[$];
	logic [31:0] seed = 32'h81f4e81f;
	int miscompares = 0, n_tests = 0, n_wake = 0, n_push = 0, m;
	always #2 clock_in = ~clock_in;
	ccmi_exec dut (.clock_in(clock_in), .reset_in(reset_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
		.cur_aux_in(cur_aux_in), .index_aux_register_in(index_aux_register_in), .sign_ext_mode_in(sign_ext_mode_in),
		.ram_config_bit_in(ram_config_bit_in), .global_int_mask_set_in(global_int_mask_set_in), .global_int_mask_clr_in(global_int_mask_clr_in),
		.int_request_in(int_request_in), .int_enable_in(int_enable_in), .nmi_n_in(nmi_n_in), .ready_in(ready_in),
		.ext_data_in(ext_data_in), .load_en_in(load_en_in), .load_addr_in(load_addr_in), .load_data_in(load_data_in),
		.peek_addr_in(peek_addr_in), .peek_data_out(peek_data_out), .busy_out(busy_out), .done_out(done_out),
		.pc_out(pc_out), .test_control_flag_out(test_control_flag_out), .sign_ext_mode_out(sign_ext_mode_out),
		.global_int_mask_out(global_int_mask_out), .idle_out(idle_out), .wake_branch_out(wake_branch_out),
		.stack_push_out(stack_push_out), .stack_data_out(stack_data_out), .ext_bus_out(ext_bus_out));
	ccmi_io_model io (.clock_in(clock_in), .read_strobe_n_in(ext_bus_out.read_strobe_n), .word_in(word),
		.delay_in(delay), .ready_out(ready_in), .data_out(ext_data_in));
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("counts: %0d compares, %0d miscompares", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic wait_done();
		int i;
		for (i = 0; i < 200; i++) begin
			@(negedge clock_in);
			if (done_out === 1'b1) break;
		end
		if (done_out !== 1'b1) chk(17'h0, 17'h1);
	endtask
	task automatic issue(input ccmi_op_e op, input logic [15:0] da, input logic [15:0] pa, input logic [4:0] k,
		input bit w);
		if (op == CCMI_OP_IO_IN) exp_pc = exp_pc + 16'h0002;
		else if (op == CCMI_OP_SWINT) exp_pc = {10'h000, k, 1'b0};
		else exp_pc = exp_pc + 16'h0001;
		expq.push_back({exp_tc, exp_pc});
		@(posedge clock_in);
		instr_valid_in <= 1'b1;
		instr_in <= '{op: op, compare_mode_field: m[1:0], data_addr: da, port_address: pa, vector_index: k};
		@(posedge clock_in);
		instr_valid_in <= 1'b0;
		if (w) wait_done();
	endtask
	task automatic load(input logic [8:0] i, input logic [15:0] v);
		@(posedge clock_in);
		load_en_in <= 1'b1;
		load_addr_in <= i;
		load_data_in <= v;
		@(posedge clock_in);
		load_en_in <= 1'b0;
	endtask
	task automatic peek(input logic [8:0] i, input logic [15:0] v);
		@(posedge clock_in);
		peek_addr_in <= i;
		@(posedge clock_in);
		@(negedge clock_in);
		chk({1'b0, peek_data_out}, {1'b0, v});
	endtask
	always @(negedge clock_in) begin
		if (wake_branch_out === 1'b1) n_wake++;
		if (stack_push_out === 1'b1) n_push++;
		if (ext_bus_out.read_strobe_n === 1'b0) sel_seen = ext_bus_out.io_space_select_n;
		if (done_out === 1'b1) begin
			if (expq.size() == 0) chk(17'h0, 17'h1);
			else chk({test_control_flag_out, pc_out}, expq.pop_front());
		end
	end
	initial begin
		#100000;
		chk(17'h0, 17'h1);
		complete_run();
	end
	initial begin
		repeat (2) @(posedge clock_in);
		reset_in <= 1'b0;
		// ===========================================
		// compare: all modes, unsigned, equal operands in the upper half
		for (m = 0; m < 8; m++) begin
			a = rnd();
			b = (m >= 4) ? a : rnd();
			exp_tc = (m[1:0] == 2'h0) ? (a == b) : (m[1:0] == 2'h1) ? (a < b) : (m[1:0] == 2'h2) ? (a > b) : (a != b);
			@(posedge clock_in);
			cur_aux_in <= a;
			index_aux_register_in <= b;
			sign_ext_mode_in <= m[0];
			issue(CCMI_OP_COMPARE, 16'h0, 16'h0, 5'h0, 1'b1);
			chk({16'h0, sign_ext_mode_out}, {16'h0, m[0]});
		end
		$display("test compare finished");
		// ===========================================
		load(9'h108, 16'h1234);
		load(9'h0ff, 16'h5a5a);
		load(9'h100, 16'h0000);
		load(9'h051, 16'h7777);
		load(9'h050, 16'hbeef);
		issue(CCMI_OP_MOVE, 16'h0308, 16'h0, 5'h0, 1'b1);
		peek(9'h109, 16'h1234);
		peek(9'h108, 16'h1234);
		issue(CCMI_OP_MOVE, 16'h02ff, 16'h0, 5'h0, 1'b1);
		peek(9'h100, 16'h5a5a);
		@(posedge clock_in);
		ram_config_bit_in <= 1'b1;
		delay <= 4'h5;
		issue(CCMI_OP_MOVE, 16'h0250, 16'h0, 5'h0, 1'b1);
		chk({16'h0, sel_seen}, 17'h1);
		peek(9'h051, 16'h7777);
		@(posedge clock_in);
		ram_config_bit_in <= 1'b0;
		issue(CCMI_OP_MOVE, 16'h0250, 16'h0, 5'h0, 1'b1);
		peek(9'h051, 16'hbeef);
		$display("test move finished");
		// ===========================================
		@(posedge clock_in);
		word <= rnd();
		delay <= 4'h0;
		issue(CCMI_OP_IO_IN, 16'h0310, 16'h1000, 5'h0, 1'b1);
		chk({1'b0, ext_bus_out.addr}, 17'h01000);
		chk({16'h0, sel_seen}, 17'h0);
		peek(9'h110, word);
		chk({15'h0, ext_bus_out.external_strobe_n, ext_bus_out.read_strobe_n}, 17'h3);
		$display("test io input finished");
		// ===========================================
		@(posedge clock_in);
		int_request_in <= 8'h04;
		issue(CCMI_OP_IDLE, 16'h0, 16'h0, 5'h0, 1'b0);
		repeat (8) @(negedge clock_in);
		chk({idle_out, pc_out}, {1'b1, exp_pc});
		chk({16'h0, busy_out}, 17'h1);
		@(posedge clock_in);
		int_enable_in <= 8'h04;
		wait_done();
		@(posedge clock_in);
		int_request_in <= 8'h00;
		global_int_mask_clr_in <= 1'b1;
		@(posedge clock_in);
		global_int_mask_clr_in <= 1'b0;
		issue(CCMI_OP_IDLE, 16'h0, 16'h0, 5'h0, 1'b0);
		repeat (4) @(posedge clock_in);
		nmi_n_in <= 1'b0;
		wait_done();
		// one edge later the watcher has surely counted the wake pulse
		@(posedge clock_in);
		nmi_n_in <= 1'b1;
		chk(17'(n_wake), 17'h1);
		chk({16'h0, global_int_mask_out}, 17'h0);
		$display("test idle finished");
		// ===========================================
		spc = exp_pc + 16'h0001;
		issue(CCMI_OP_SWINT, 16'h0, 16'h0, 5'h1f, 1'b1);
		chk({global_int_mask_out, stack_data_out}, {1'b1, spc});
		@(posedge clock_in);
		chk(17'(n_push), 17'h1);
		// set and clear of the mask in one cycle: set must win
		global_int_mask_clr_in <= 1'b1;
		@(posedge clock_in);
		global_int_mask_set_in <= 1'b1;
		@(posedge clock_in);
		global_int_mask_set_in <= 1'b0;
		global_int_mask_clr_in <= 1'b0;
		@(negedge clock_in);
		chk({16'h0, global_int_mask_out}, 17'h1);
		$display("test software interrupt finished");
		repeat (4) @(negedge clock_in);
		complete_run();
	end
endmodule
`default_nettype wire
